/* File: rfc_pkg.sv */
// Purpose: Shared constants and types for the radio front-end control port.
// Assumes: ref_clk at 10 MHz; radio reference clock arrives as a sampled pin.
// Notes: Registers are 32-bit words on classic Wishbone, byte addressed.
// Summary of operation
// R01: Bit-stream pin driven high after reset.
// R02: Bit stream paced by twelve radio clock edges.
// R03: Radio clock sampled, twelve edges make one bit.
// R04: Receive: strobe low correlating, high once synced.
// R05: Transmit: strobe high enables radio transmitter.
// R06: Chip enable gates radio power; serial still works.
// R07: Link power-down drops chip enable under hardware control.
// R08: Radio pins float until alternate function selected.
// R09: Device is serial master, drives clock and load.
// R10: Frame is header, direction, address, sixteen data.
// R11: Header is 101b except for fast writes.
// R12: Radio copies data on direction bit zero.
// R13: Every field shifted most significant bit first.
// R14: Radio loads register on rise after load.
// R15: Radio releases data line on rise after load.
// R16: Read data field driven by radio, then returned.
// R17: Three sequencer state bits shown on pins.
// R18: Function choice ignored unless alternate enable set.
// R19: Write data changes on falling shift clock.
// R20: Read data sampled on falling shift clock.
// R21: Reads always capture a full sixteen bits.
// R22: Load strobe high one shift period after data.
// R23: Shift clock divided from main clock, idle low.
`default_nettype none

package rfc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ALT_EN = 8'h04;
  localparam logic [7:0] OFS_ALT_SEL = 8'h08;
  localparam logic [7:0] OFS_SER_CMD = 8'h0C;
  localparam logic [7:0] OFS_SER_STAT = 8'h10;
  localparam logic [7:0] OFS_MODEM = 8'h14;

  // Port I pin positions of the radio functions
  localparam int PIN_SYNC = 0;
  localparam int PIN_CE = 1;
  localparam int PIN_SEQ1 = 2;
  localparam int PIN_SCLK = 3;
  localparam int PIN_SERIAL_DATA_LINE = 4;
  localparam int PIN_SLE = 5;
  localparam int PIN_SEQ2 = 6;
  localparam int PIN_SEQ3 = 7;
  // Function choice value that selects the radio function on each pin
  localparam logic [7:0] RADIO_CHOICE = 8'hC0;

  // Frame layout and timing
  localparam logic [2:0] FRAME_HEADER = 3'h5;
  localparam logic [4:0] FRAME_TOP_BIT = 5'h18;
  localparam logic [4:0] DATA_BITS = 5'h10;
  localparam int REF_CLK_NS = 100;
  localparam int SCLK_HALF_MIN_NS = 400;
  localparam logic [7:0] SCLK_HALF_MIN = 8'((SCLK_HALF_MIN_NS + REF_CLK_NS - 1) / REF_CLK_NS);
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hB;
  localparam logic [3:0] RX_SAMPLE_EDGE = 4'h5;
  localparam int SYNC_W = 3;

  // Control register: shift clock half period, modem and strobe controls
  typedef struct packed {
    logic [7:0] half;
    logic modem_en;
    logic sync_lvl;
    logic tx_mode;
    logic ce_sw;
  } rfc_ctrl_t;
  localparam rfc_ctrl_t CTRL_RST = 12'h040;

  // Serial command register layout
  typedef struct packed {
    logic fast_write_flag;
    logic [2:0] hdr;
    logic rw;
    logic [4:0] addr;
    logic [15:0] data;
  } rfc_cmd_t;

  // Port I drive carrier
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } rfc_pin_t;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_SHIFT = 2'b01,
    SER_LOAD = 2'b10,
    SER_TAIL = 2'b11
  } rfc_ser_st_t;

  // Synchroniser state
  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
  } rfc_sync_st_t;

  // Divider state
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } rfc_div_st_t;

  // Main block state
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    rfc_ctrl_t ctrl;
    logic [7:0] alt_en;
    logic [7:0] alt_sel;
    rfc_cmd_t cmd;
    logic busy;
    logic [15:0] rd_data;
    rfc_ser_st_t ser;
    logic phase;
    logic [4:0] bitn;
    logic sclk;
    logic serial_data_line_o;
    logic serial_data_line_oe;
    logic serial_load_strobe;
    logic ref_prev;
    logic [3:0] edge_cnt;
    logic [7:0] tx_byte;
    logic [2:0] tx_bitn;
    logic [7:0] rx_byte;
    logic bs_out;
    logic bs_oe;
    rfc_pin_t pins;
  } rfc_top_st_t;

  localparam rfc_top_st_t TOP_RST = '{
    ctrl: CTRL_RST,
    ser: SER_IDLE,
    tx_bitn: 3'h7,
    serial_data_line_oe: 1'b1,
    bs_out: 1'b1,
    bs_oe: 1'b1,
    default: '0
  };

endpackage

`default_nettype wire

/* File: rfc_sync.sv */
// Purpose: Two-flop synchroniser for pins from outside the ref_clk domain.
// Assumes: Inputs are slow levels relative to ref_clk.
// Notes: The first stage feeds only the second stage.
`default_nettype none

module rfc_sync (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [rfc_pkg::SYNC_W-1:0] d,
  output logic [rfc_pkg::SYNC_W-1:0] q
);

  rfc_pkg::rfc_sync_st_t st_r; // Both stages
  rfc_pkg::rfc_sync_st_t st_nxt; // Next stages

  // Shift the pins through two stages
  always_comb
  begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  // Register the stages
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;

endmodule

`default_nettype wire

/* File: rfc_div.sv */
// Purpose: Shift clock divider, pulses once per half shift period.
// Assumes: half is at least the minimum half period.
// Notes: Counter rests at zero while not running, so each frame starts clean.
`default_nettype none

module rfc_div (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [7:0] half,
  output logic tick
);

  rfc_pkg::rfc_div_st_t st_r; // Counter and tick
  rfc_pkg::rfc_div_st_t st_nxt; // Next counter and tick

  // Count ref_clk cycles of one half period
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (!run)
    begin
      st_nxt.cnt = 8'h00;
    end
    else if (st_r.cnt == half - 8'h01)
    begin
      st_nxt.cnt = 8'h00;
      st_nxt.tick = 1'b1;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
  end

  // Register the counter
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

endmodule

`default_nettype wire

/* File: rfc_top.sv */
// Purpose: Radio front-end control port: modem pins, chip enable, serial master.
// Assumes: Classic Wishbone slave; radio pins sampled through two flops.
// Notes: All outputs are registered; pin drives follow register writes by one cycle.
`default_nettype none

module rfc_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic radio_ref_clock,
  input wire logic radio_bit_stream_in,
  output logic radio_bit_stream_out,
  output logic radio_bit_stream_oe,
  input wire logic [7:0] port_i_in,
  output var rfc_pkg::rfc_pin_t port_i_drive,
  input wire logic [2:0] sequencer_state,
  input wire logic link_power_down,
  input wire logic hw_clk_ctrl_en
);

  rfc_pkg::rfc_top_st_t st_r; // Whole block state
  rfc_pkg::rfc_top_st_t st_nxt; // Next block state
  logic [rfc_pkg::SYNC_W-1:0] pin_sync; // Synchronised ref clock, stream, data line
  logic tick; // Half shift period elapsed
  logic [7:0] half_eff; // Half period after clamping
  logic [24:0] frame; // Serial frame being shifted
  logic ref_rise; // Rising edge of radio reference clock
  logic [7:0] pin_out; // Pin values before gating
  logic [7:0] pin_own; // Pins the block wants to drive

  // Byte-lane merge of a bus write into a register
  function automatic logic [31:0] wmask(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Bring in pins from the radio
  rfc_sync u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d({port_i_in[rfc_pkg::PIN_SERIAL_DATA_LINE], radio_bit_stream_in, radio_ref_clock}),
    .q(pin_sync)
  );

  // Shift clock half-period divider
  rfc_div u_div (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(st_r.busy),
    .half(half_eff),
    .tick(tick)
  );

  // Frame, edge and pin helpers
  always_comb
  begin
    half_eff = (st_r.ctrl.half < rfc_pkg::SCLK_HALF_MIN) ? rfc_pkg::SCLK_HALF_MIN
                                                          : st_r.ctrl.half; // R23
    frame = {st_r.cmd.fast_write_flag ? st_r.cmd.hdr : rfc_pkg::FRAME_HEADER, // R11
             st_r.cmd.rw, st_r.cmd.addr, st_r.cmd.data}; // R10
    ref_rise = pin_sync[0] && !st_r.ref_prev; // R03
    pin_out = {sequencer_state[2], sequencer_state[1], st_r.serial_load_strobe, st_r.serial_data_line_o,
               st_r.sclk, sequencer_state[0],
               st_r.ctrl.ce_sw && !(hw_clk_ctrl_en && link_power_down), // R06 R07
               st_r.ctrl.sync_lvl}; // R04 R05 R17
    pin_own = 8'hFF;
    pin_own[rfc_pkg::PIN_SERIAL_DATA_LINE] = st_r.serial_data_line_oe;
  end

  // Next-state logic for bus, serial engine, modem and pins
  always_comb
  begin
    st_nxt = st_r;
    // Bus: answer one cycle after the strobe, drop ack the cycle after
    st_nxt.ack = wb_cyc_i && wb_stb_i && !st_r.ack;
    st_nxt.rdat = 32'h0000_0000;
    if (wb_cyc_i && wb_stb_i && !st_r.ack)
    begin
      if (wb_we_i)
      begin
        unique case (wb_adr_i)
          rfc_pkg::OFS_CTRL:
          begin
            st_nxt.ctrl = 12'(wmask({20'h00000, st_r.ctrl}, wb_dat_i, wb_sel_i));
          end
          rfc_pkg::OFS_ALT_EN:
          begin
            st_nxt.alt_en = 8'(wmask({24'h000000, st_r.alt_en}, wb_dat_i, wb_sel_i));
          end
          rfc_pkg::OFS_ALT_SEL:
          begin
            st_nxt.alt_sel = 8'(wmask({24'h000000, st_r.alt_sel}, wb_dat_i, wb_sel_i));
          end
          rfc_pkg::OFS_SER_CMD:
          begin
            // A new frame starts only when the engine is idle
            if (!st_r.busy)
            begin
              st_nxt.cmd = 26'(wmask({6'h00, st_r.cmd}, wb_dat_i, wb_sel_i));
              st_nxt.busy = 1'b1;
              st_nxt.ser = rfc_pkg::SER_SHIFT;
              st_nxt.bitn = rfc_pkg::FRAME_TOP_BIT;
              st_nxt.phase = 1'b0;
            end
          end
          rfc_pkg::OFS_MODEM:
          begin
            if (wb_sel_i[0])
            begin
              st_nxt.tx_byte = wb_dat_i[7:0];
            end
          end
          default:
          begin
            // Unmapped or read-only: acknowledged, no effect
          end
        endcase
      end
      else
      begin
        unique case (wb_adr_i)
          rfc_pkg::OFS_CTRL: st_nxt.rdat = {20'h00000, st_r.ctrl};
          rfc_pkg::OFS_ALT_EN: st_nxt.rdat = {24'h000000, st_r.alt_en};
          rfc_pkg::OFS_ALT_SEL: st_nxt.rdat = {24'h000000, st_r.alt_sel};
          rfc_pkg::OFS_SER_CMD: st_nxt.rdat = {6'h00, st_r.cmd};
          rfc_pkg::OFS_SER_STAT: st_nxt.rdat = {st_r.rd_data, 15'h0000, st_r.busy};
          rfc_pkg::OFS_MODEM: st_nxt.rdat = {16'h0000, st_r.rx_byte, st_r.tx_byte};
          default: st_nxt.rdat = 32'h0000_0000;
        endcase
      end
    end

    // Frame start: first header bit goes out with the clock low
    // Taken from the command just accepted; the old one may carry another header
    if (st_r.ser == rfc_pkg::SER_IDLE && st_nxt.ser == rfc_pkg::SER_SHIFT)
    begin
      st_nxt.serial_data_line_o = st_nxt.cmd.fast_write_flag ? st_nxt.cmd.hdr[2]
                                                 : rfc_pkg::FRAME_HEADER[2]; // R11 R13
      st_nxt.serial_data_line_oe = 1'b1;
    end

    // Serial engine advances on each half period
    if (tick)
    begin
      if (!st_r.phase)
      begin
        // End of low half: shift clock rises
        st_nxt.sclk = 1'b1; // R09
        st_nxt.phase = 1'b1;
      end
      else
      begin
        // End of high half: shift clock falls
        st_nxt.sclk = 1'b0; // R19
        st_nxt.phase = 1'b0;
        unique case (st_r.ser)
          rfc_pkg::SER_IDLE:
          begin
            st_nxt.busy = 1'b0;
          end
          rfc_pkg::SER_SHIFT:
          begin
            // Read data sampled on the falling edge
            if (st_r.cmd.rw && st_r.bitn < rfc_pkg::DATA_BITS)
            begin
              st_nxt.rd_data[st_r.bitn[3:0]] = pin_sync[2]; // R20 R21
            end
            if (st_r.bitn == 5'h00)
            begin
              // Last data bit done: load strobe for one period
              st_nxt.ser = rfc_pkg::SER_LOAD;
              st_nxt.serial_load_strobe = 1'b1; // R22
              st_nxt.serial_data_line_o = 1'b0;
            end
            else
            begin
              st_nxt.bitn = st_r.bitn - 5'h01;
              st_nxt.serial_data_line_o = frame[st_r.bitn - 5'h01]; // R13 R19
              // Hand the line to the radio for a read data field
              st_nxt.serial_data_line_oe = !(st_r.cmd.rw && (st_r.bitn - 5'h01) < rfc_pkg::DATA_BITS); // R16
            end
          end
          rfc_pkg::SER_LOAD:
          begin
            // Radio acted on the rise inside this period
            st_nxt.serial_load_strobe = 1'b0; // R22
            st_nxt.ser = rfc_pkg::SER_TAIL;
          end
          rfc_pkg::SER_TAIL:
          begin
            // Line taken back after the following rising edge
            st_nxt.ser = rfc_pkg::SER_IDLE;
            st_nxt.busy = 1'b0;
            st_nxt.serial_data_line_oe = 1'b1; // R16
          end
        endcase
      end
    end

    // Modem: twelve reference edges per bit
    st_nxt.ref_prev = pin_sync[0];
    if (ref_rise)
    begin
      st_nxt.edge_cnt = (st_r.edge_cnt == rfc_pkg::OVERSAMPLE_LAST) ? 4'h0
                                                                    : st_r.edge_cnt + 4'h1; // R02
      if (st_r.edge_cnt == rfc_pkg::OVERSAMPLE_LAST)
      begin
        st_nxt.tx_bitn = st_r.tx_bitn - 3'h1; // R02
      end
      if (st_r.edge_cnt == rfc_pkg::RX_SAMPLE_EDGE && st_r.ctrl.modem_en && !st_r.ctrl.tx_mode)
      begin
        st_nxt.rx_byte = {st_r.rx_byte[6:0], pin_sync[1]};
      end
    end
    // Stream pin high unless the modem is enabled
    if (st_r.ctrl.modem_en)
    begin
      st_nxt.bs_oe = st_r.ctrl.tx_mode;
      st_nxt.bs_out = st_r.ctrl.tx_mode ? st_r.tx_byte[st_r.tx_bitn] : 1'b1; // R02
    end
    else
    begin
      st_nxt.bs_oe = 1'b1; // R01
      st_nxt.bs_out = 1'b1; // R01
    end

    // Pins drive only with alternate function on and the radio choice picked
    st_nxt.pins.out = pin_out;
    st_nxt.pins.oe = pin_own & st_r.alt_en & ~(st_r.alt_sel ^ rfc_pkg::RADIO_CHOICE); // R08 R18
  end

  // Register all state
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= rfc_pkg::TOP_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state
  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.rdat;
  assign radio_bit_stream_out = st_r.bs_out;
  assign radio_bit_stream_oe = st_r.bs_oe;
  assign port_i_drive = st_r.pins;

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  chk_stream_high: assert property ( // R01
    $past(!st_r.ctrl.modem_en) |-> (radio_bit_stream_oe && radio_bit_stream_out))
    else $error("stream pin not driven high while modem is off");

  chk_bit_pace: assert property ( // R02
    $changed(st_r.tx_bitn) |-> $past(st_r.edge_cnt) == 4'hB)
    else $error("stream bit advanced off the twelfth edge");

  chk_sync_level: assert property ( // R04
    port_i_drive.out[0] == $past(st_r.ctrl.sync_lvl))
    else $error("sync strobe does not follow its control bit");

  chk_ce_cut: assert property ( // R07
    $past(hw_clk_ctrl_en && link_power_down) |-> !port_i_drive.out[1])
    else $error("chip enable high during link power-down");

  chk_pin_float: assert property ( // R08
    ##1 !$past(st_r.alt_en[4]) |-> !port_i_drive.oe[4])
    else $error("data line driven without alternate function");

  chk_header_bits: assert property ( // R11
    (st_r.ser == rfc_pkg::SER_SHIFT && !st_r.cmd.fast_write_flag && st_r.bitn == 5'h17
      && $changed(st_r.bitn))
      |-> !st_r.serial_data_line_o && $past(st_r.serial_data_line_o))
    else $error("header pattern wrong");

  chk_read_release: assert property ( // R16
    (st_r.ser == rfc_pkg::SER_SHIFT && st_r.cmd.rw && st_r.bitn < 5'h10) |-> !st_r.serial_data_line_oe)
    else $error("data line driven during read data field");

  chk_data_fall: assert property ( // R19
    ($changed(st_r.serial_data_line_o) && $past(st_r.ser) != rfc_pkg::SER_IDLE) |-> $fell(st_r.sclk))
    else $error("serial data changed away from falling clock");

  chk_load_width: assert property ( // R22
    $rose(st_r.serial_load_strobe) |-> (st_r.serial_load_strobe && !st_r.sclk) [*4] ##1 st_r.serial_load_strobe [*4])
    else $error("load strobe shorter than one shift period");

  chk_sclk_idle: assert property ( // R23
    (st_r.ser == rfc_pkg::SER_IDLE && !st_r.busy) |-> !st_r.sclk)
    else $error("shift clock not idle low between frames");

endmodule

`default_nettype wire

/* File: rfc_radio_model.sv */
// Purpose: Radio serial slave model seen from the control port pins.
// Assumes: Shift clock and load strobe arrive as resolved pin levels.
// Notes: Register file starts from a fixed pattern the bench mirrors.
`default_nettype none
module rfc_radio_model (
  input wire logic sclk,
  input wire logic serial_load_strobe,
  input wire logic serial_data_line,
  output logic serial_data_line_o,
  output logic serial_data_line_oe,
  output logic [24:0] frame
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] regs [32]; // Radio register file
  logic [24:0] sh; // Bits received this frame
  logic [15:0] rv; // Word being read out
  logic rd; // Read frame in progress
  int n; // Rising edges seen in this frame
  initial
  begin
    serial_data_line_o = 1'b0;
    serial_data_line_oe = 1'b0;
    n = 0;
    rd = 1'b0;
    sh = '0;
    frame = '0;
    foreach (regs[i]) regs[i] = 16'(i * 16'h0F1D);
  end
  // Slave samples and drives on rising shift clock edges
  always @(posedge sclk)
  begin
    if (serial_load_strobe)
    begin
      frame = sh;
      if (!sh[21] && sh[24:22] == 3'h5) regs[sh[20:16]] = sh[15:0];
      serial_data_line_oe = 1'b0;
      rd = 1'b0;
      n = -1; // The rise after the load period closes the frame
    end
    else
    begin
      n++;
      if (n > 0) sh = {sh[23:0], serial_data_line};
      // Header, direction and address are in: decide on a read
      if (n == 9)
      begin
        rd = (sh[8:6] == 3'h5) && sh[5];
        rv = regs[sh[4:0]];
      end
      // Data field driven MSB first from the first data slot
      if (rd && n >= 10)
      begin
        serial_data_line_oe = 1'b1;
        serial_data_line_o = rv[25 - n];
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb_radio_front_end_control_port.sv */
// Purpose: Self-checking bench for the radio front-end control port.
// Assumes: Wishbone answers within 50 cycles; frames end within 900 polls.
// Notes: Radio clock runs free at 800 ns, unrelated in phase to ref_clk.
`default_nettype none
module tb_radio_front_end_control_port;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] stream_pat = 8'hD0; // No rotation equals its reverse
  logic ref_clk, rst_n, wb_cyc, wb_stb, wb_we, wb_ack, rclk, bs_in, bs_out, bs_oe;
  logic lpd, hce, last_sd, r_o, r_oe, sclk_q, sd_q, sd_oe_q, m, s_ok;
  logic [7:0] wb_adr, rxb, en, sel;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat, wb_rd, wb_q, seed, v;
  logic [2:0] seq;
  logic [24:0] frame;
  logic [4:0] a;
  logic [15:0] d;
  logic [15:0] shadow [32]; // Expected radio registers
  logic s [192]; // Stream samples, one per radio clock
  int n_fail, samples_checked, half_exp, hi_cnt, rises, sle_rises, gen_i;
  rfc_pkg::rfc_pin_t pd;
  wire logic sclk_p = pd.out[3] & pd.oe[3];
  wire logic sle_p = pd.out[5] & pd.oe[5];
  // Released data line shows a changing level, never the last one
  wire logic sd_line = pd.oe[4] ? pd.out[4] : (r_oe ? r_o : ~last_sd);

  rfc_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .radio_ref_clock(rclk),
    .radio_bit_stream_in(bs_in), .radio_bit_stream_out(bs_out),
    .radio_bit_stream_oe(bs_oe), .port_i_in({pd.out[7:5], sd_line, pd.out[3:0]}),
    .port_i_drive(pd), .sequencer_state(seq), .link_power_down(lpd),
    .hw_clk_ctrl_en(hce));
  rfc_radio_model u_radio (.sclk(sclk_p), .serial_load_strobe(sle_p), .serial_data_line(sd_line), .serial_data_line_o(r_o),
    .serial_data_line_oe(r_oe), .frame(frame));

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial
  begin
    rclk = 1'b0;
    #137;
    forever #400 rclk = ~rclk;
  end
  // Incoming stream: pattern MSB first, twelve radio clocks a bit
  always @(posedge rclk)
  begin
    gen_i <= (gen_i + 1) % 96;
    bs_in <= stream_pat[7 - gen_i / 12];
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] rotl(input logic [7:0] b, input int r);
    return (b << r) | (b >> (8 - r));
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Classic single Wishbone cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] dt);
    int k;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= ad;
    wb_dat <= dt;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (wb_ack !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      n_fail++;
      tally_and_finish();
    end
    wb_q = wb_rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge ref_clk);
  endtask
  // One serial frame, a refused command while busy, then wire and data checks
  task automatic frame_run(input logic fw, input logic [2:0] h, input logic rw);
    int k;
    rises = 0;
    sle_rises = 0;
    wb(1'b1, rfc_pkg::OFS_SER_CMD, {6'h0, fw, h, rw, a, d});
    wb(1'b0, rfc_pkg::OFS_SER_STAT, 32'h0);
    check(wb_q[0], 1'b1);
    wb(1'b1, rfc_pkg::OFS_SER_CMD, {10'h0, ~a, ~d});
    k = 0;
    do
    begin
      wb(1'b0, rfc_pkg::OFS_SER_STAT, 32'h0);
      k++;
    end
    while (wb_q[0] !== 1'b0 && k < 900);
    if (k >= 900)
    begin
      n_fail++;
      tally_and_finish();
    end
    check(rises, 27);
    check(sle_rises, 1);
    check(frame[24:16], {fw ? h : 3'h5, rw, a});
    if (rw)
      check(wb_q[31:16], shadow[a]);
    else
      check(frame[15:0], d);
    if (!rw && !fw) shadow[a] = d;
  endtask

  // Wire monitor: shift clock high time, data edges, line ownership
  always @(posedge ref_clk)
  begin
    if (sclk_p && !sclk_q) rises++;
    if (sclk_p && !sclk_q && sle_p) sle_rises++;
    if (!sclk_p && sclk_q) check(hi_cnt, half_exp);
    hi_cnt = sclk_p ? hi_cnt + 1 : 0;
    if (pd.oe[4] && sd_oe_q && pd.out[4] !== sd_q) check(sclk_p, 1'b0);
    if (rst_n) check(pd.oe[4] & r_oe, 1'b0);
    sclk_q = sclk_p;
    sd_q = pd.out[4];
    sd_oe_q = pd.oe[4];
    last_sd <= sd_line;
  end

  initial
  begin
    seed = 32'h0000_C9DB;
    {n_fail, samples_checked, hi_cnt, gen_i} = '0;
    {rst_n, wb_cyc, wb_stb, wb_we, lpd, hce, bs_in, sclk_q, sd_q, sd_oe_q} = '0;
    {wb_adr, wb_dat, seq, last_sd} = '0;
    wb_sel = 4'hF;
    half_exp = 4;
    foreach (shadow[i]) shadow[i] = 16'(i * 16'h0F1D);
    repeat (12) @(posedge ref_clk);
    check({bs_out, bs_oe}, 2'b11);
    check(pd.oe, 8'h00);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    // Reset values, and an unmapped place reads zero
    wb(1'b0, rfc_pkg::OFS_CTRL, 32'h0);
    check(wb_q, 32'h0000_0040);
    wb(1'b0, rfc_pkg::OFS_ALT_SEL, 32'h0);
    check(wb_q, 32'h0);
    wb(1'b0, 8'h3C, 32'h0);
    check(wb_q, 32'h0);
    // Function choice only counts where the alternate enable is set
    for (int i = 0; i < 7; i++)
    begin
      v = rnd();
      en = (i == 6) ? 8'hFF : v[7:0];
      sel = (i == 6) ? rfc_pkg::RADIO_CHOICE : v[15:8];
      wb(1'b1, rfc_pkg::OFS_ALT_EN, {24'h0, en});
      wb(1'b1, rfc_pkg::OFS_ALT_SEL, {24'h0, sel});
      wb(1'b0, rfc_pkg::OFS_ALT_SEL, 32'h0);
      check(wb_q[7:0], sel);
      check(pd.oe, en & ~(sel ^ rfc_pkg::RADIO_CHOICE));
    end
    // Strobe, chip enable and sequencer pins against random controls
    for (int i = 0; i < 16; i++)
    begin
      v = rnd();
      wb(1'b1, rfc_pkg::OFS_CTRL, {20'h0, 8'h04, 1'b0, v[1], v[2], v[0]});
      hce <= v[3];
      lpd <= v[4];
      seq <= v[7:5];
      repeat (3) @(posedge ref_clk);
      check(pd.out[1], v[0] & ~(v[3] & v[4]));
      check(pd.out[0], v[1]);
      check({pd.out[7:6], pd.out[2]}, v[7:5]);
    end
    // Frames with the radio powered down, three divider settings
    for (int h = 2; h <= 6; h += 2)
    begin
      half_exp = (h < 4) ? 4 : h;
      wb(1'b1, rfc_pkg::OFS_CTRL, 32'(h) << 4);
      v = rnd();
      a = v[4:0];
      d = v[31:16];
      frame_run(1'b0, 3'h5, 1'b0);
      frame_run(1'b0, 3'h5, 1'b1);
      a = a ^ 5'h3;
      frame_run(1'b0, 3'h5, 1'b1);
      frame_run(1'b1, 3'h3, 1'b0);
    end
    // Transmit stream: pattern MSB first, twelve radio clocks a bit
    wb(1'b1, rfc_pkg::OFS_MODEM, {24'h0, stream_pat});
    wb(1'b1, rfc_pkg::OFS_CTRL, 32'h0000_004A);
    repeat (24) @(posedge rclk);
    for (int i = 0; i < 192; i++)
    begin
      @(posedge rclk);
      s[i] = bs_out;
    end
    s_ok = 1'b0;
    for (int o = 0; o < 96; o++)
    begin
      m = 1'b1;
      for (int i = 0; i < 96; i++)
        if (s[o + i] !== stream_pat[7 - i / 12]) m = 1'b0;
      if (m) s_ok = 1'b1;
    end
    check(s_ok, 1'b1);
    // Receive stream lands MSB first; the pin is released
    @(posedge ref_clk);
    wb(1'b1, rfc_pkg::OFS_CTRL, 32'h0000_0048);
    repeat (200) @(posedge rclk);
    @(posedge ref_clk);
    wb(1'b0, rfc_pkg::OFS_MODEM, 32'h0);
    rxb = wb_q[15:8];
    m = 1'b0;
    for (int r = 0; r < 8; r++)
      if (rxb === rotl(stream_pat, r)) m = 1'b1;
    check(m, 1'b1);
    check(bs_oe, 1'b0);
    // Modem off returns the stream pin to a driven high
    wb(1'b1, rfc_pkg::OFS_CTRL, 32'h0000_0040);
    repeat (2) @(posedge ref_clk);
    check({bs_out, bs_oe}, 2'b11);
    tally_and_finish();
  end
endmodule
`default_nettype wire
